// ==== hdl/arx_defs.vh ====
// Constants for the audio route crossbar: codes, indexes, resets, field layout
`ifndef ARX_DEFS_VH
`define ARX_DEFS_VH

// Source codes
`define ARX_SRC_MUTE 5'h00
`define ARX_SRC_HOST_MEAN 5'h01
`define ARX_SRC_HOST_HDIFF 5'h02
`define ARX_SRC_SER_MEAN 5'h03
`define ARX_SRC_SER_HDIFF 5'h04
`define ARX_SRC_PIPE0 5'h05
`define ARX_SRC_PIPE1 5'h06
`define ARX_SRC_HOST0 5'h07
`define ARX_SRC_HOST1 5'h08
`define ARX_SRC_SER0 5'h09
`define ARX_SRC_SER1 5'h0a
`define ARX_SRC_MIC0 5'h0b
`define ARX_SRC_MIC1 5'h0c
`define ARX_SRC_PACK_PIPE 5'h0d
`define ARX_SRC_PACK_MIC 5'h0e
`define ARX_SRC_PACK_REF 5'h0f
`define ARX_SRC_PACK_ALL 5'h10
`define ARX_SRC_LAST 5'h10

// Destination indexes
`define ARX_DST_HOST0 3'h0
`define ARX_DST_HOST1 3'h1
`define ARX_DST_SER0 3'h2
`define ARX_DST_SER1 3'h3
`define ARX_DST_REF0 3'h4
`define ARX_DST_REF1 3'h5
`define ARX_NUM_DST 6

// Command opcodes
`define ARX_OP_MAP 2'h0
`define ARX_OP_SHIFT 2'h1
`define ARX_OP_READ 2'h2

// Reset values
`define ARX_RST_SRC_HOST0 5'h05
`define ARX_RST_SRC_HOST1 5'h06
`define ARX_RST_SRC_SER0 5'h05
`define ARX_RST_SRC_SER1 5'h09
`define ARX_RST_SRC_REF0 5'h07
`define ARX_RST_SRC_REF1 5'h08
`define ARX_RST_SHIFT 8'h00

// Readback word layout: {last, dest, source, shift}
`define ARX_RB_SHIFT_LSB 0
`define ARX_RB_SRC_LSB 8
`define ARX_RB_DST_LSB 13
`define ARX_RB_LAST_BIT 16
`define ARX_RB_W 17

// Last packing slot index per 16 kHz period
`define ARX_PACK_LAST_PHASE 2'h2

`endif

// ==== hdl/arx_gain.v ====
// Power-of-two gain stage: signed shift with saturation on left shift
`timescale 1ns/1ps
module arx_gain #(
  parameter W = 24
) (
  // Sample in
  input wire [W-1:0] din,
  // Signed shift, positive is left
  input wire signed [7:0] shift,
  // Sample out
  output reg [W-1:0] dout
);

  reg [2*W-1:0] wide;
  integer mag;

  // Left shift saturates to full scale, right shift is arithmetic
  always @* begin
    wide = {{W{din[W-1]}}, din};
    mag = shift;
    dout = din;
    if (mag >= 0) begin
      if (mag > W) begin
        mag = W;
      end
      wide = wide << mag;
      if (wide[2*W-1:W-1] != {(W+1){din[W-1]}}) begin
        dout = din[W-1] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};
      end else begin
        dout = wide[W-1:0];
      end
    end else begin
      mag = -mag;
      if (mag > W - 1) begin
        mag = W - 1;
      end
      dout = $signed(din) >>> mag;
    end
  end

endmodule // arx_gain

// ==== hdl/arx_skid2.v ====
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module arx_skid2 #(
  parameter W = 17
) (
  // Clock and reset
  input wire sys_clk,
  input wire rstn,
  // Filling side
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  // Draining side
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);

  reg [W-1:0] head_r;
  reg [W-1:0] tail_r;
  reg head_v_r;
  reg tail_v_r;
  wire push;
  wire pop;

  // Accept only while the second slot is free
  assign in_ready = ~tail_v_r;
  assign out_valid = head_v_r;
  assign out_data = head_r;
  assign push = in_valid & ~tail_v_r;
  assign pop = head_v_r & out_ready;

  // Head always holds the oldest word
  always @(posedge sys_clk) begin
    if (!rstn) begin
      head_r <= {W{1'b0}};
      tail_r <= {W{1'b0}};
      head_v_r <= 1'b0;
      tail_v_r <= 1'b0;
    end else if (pop) begin
      if (tail_v_r) begin
        head_r <= tail_r;
        tail_v_r <= 1'b0;
      end else if (push) begin
        head_r <= in_data;
      end else begin
        head_v_r <= 1'b0;
      end
    end else if (push) begin
      if (head_v_r) begin
        tail_r <= in_data;
        tail_v_r <= 1'b1;
      end else begin
        head_r <= in_data;
        head_v_r <= 1'b1;
      end
    end
  end

endmodule // arx_skid2

// ==== hdl/arx_crossbar.v ====
// Audio route crossbar: six destinations, seventeen sources, per-destination gain
`timescale 1ns/1ps
`include "arx_defs.vh"
module arx_crossbar #(
  parameter W = 24
) (
  // Clock and reset
  input wire sys_clk,
  input wire rstn,
  // Frame timing: 48 kHz frame pulse and 16 kHz new-sample pulse
  input wire in_stb,
  input wire pk_stb,
  // 48 kHz inputs
  input wire [W-1:0] host_in_chan0,
  input wire [W-1:0] host_in_chan1,
  input wire [W-1:0] serial_in_chan0,
  input wire [W-1:0] serial_in_chan1,
  // 16 kHz inputs
  input wire [W-1:0] pipe_out_chan0,
  input wire [W-1:0] pipe_out_chan1,
  input wire [W-1:0] mic_chan0,
  input wire [W-1:0] mic_chan1,
  input wire [W-1:0] ref16_chan0,
  input wire [W-1:0] ref16_chan1,
  // Routed outputs
  output reg [W-1:0] host_out_chan0,
  output reg [W-1:0] host_out_chan1,
  output reg [W-1:0] serial_out_chan0,
  output reg [W-1:0] serial_out_chan1,
  output reg [W-1:0] echo_ref_chan0,
  output reg [W-1:0] echo_ref_chan1,
  output reg out_stb,
  // Command port
  input wire cmd_valid,
  output reg cmd_ready,
  input wire [1:0] cmd_op,
  input wire [2:0] cmd_dest,
  input wire [7:0] cmd_arg,
  output reg cmd_err,
  // Readback stream
  output wire rb_valid,
  input wire rb_ready,
  output wire [2:0] rb_dest,
  output wire [4:0] rb_src,
  output wire [7:0] rb_shift,
  output wire rb_last
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  localparam ST_IDLE = 2'b01;
  localparam ST_DUMP = 2'b10;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [2:0] rb_idx_r;
  reg [4:0] src_sh_r [0:`ARX_NUM_DST-1];
  reg [7:0] shift_sh_r [0:`ARX_NUM_DST-1];
  reg [4:0] src_act_r [0:`ARX_NUM_DST-1];
  reg [7:0] shift_act_r [0:`ARX_NUM_DST-1];
  reg [1:0] phase_r;
  reg [W-1:0] pipe0_r;
  reg [W-1:0] pipe1_r;
  reg [W-1:0] mic0_r;
  reg [W-1:0] mic1_r;
  reg [W-1:0] ref0_r;
  reg [W-1:0] ref1_r;
  wire [1:0] phase_cur;
  wire [W-1:0] pipe0_h;
  wire [W-1:0] pipe1_h;
  wire [W-1:0] mic0_h;
  wire [W-1:0] mic1_h;
  wire [W-1:0] ref0_h;
  wire [W-1:0] ref1_h;
  wire [W-1:0] host_mean;
  wire [W-1:0] host_hdiff;
  wire [W-1:0] ser_mean;
  wire [W-1:0] ser_hdiff;
  wire [`ARX_NUM_DST*W-1:0] gained;
  wire cmd_take;
  wire dest_ok;
  wire src_ok;
  wire buf_in_valid;
  wire buf_in_ready;
  wire [`ARX_RB_W-1:0] buf_in_data;
  wire [`ARX_RB_W-1:0] buf_out_data;
  integer i;

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Half of a plus or minus b, one bit wider inside so it never overflows
  function [W-1:0] half2;
    input [W-1:0] a;
    input [W-1:0] b;
    input sub;
    reg [W:0] s;
    begin
      s = sub ? {a[W-1], a} - {b[W-1], b} : {a[W-1], a} + {b[W-1], b};
      half2 = s[W:1];
    end
  endfunction

  // Slot selection for packed streams, last slot of three
  function [W-1:0] pack3;
    input [1:0] ph;
    input [W-1:0] s0;
    input [W-1:0] s1;
    input [W-1:0] s2;
    begin
      case (ph)
        2'h0: pack3 = s0;
        2'h1: pack3 = s1;
        default: pack3 = s2;
      endcase
    end
  endfunction

  // Default source per destination
  function [4:0] rst_src;
    input integer d;
    begin
      case (d)
        0: rst_src = `ARX_RST_SRC_HOST0;
        1: rst_src = `ARX_RST_SRC_HOST1;
        2: rst_src = `ARX_RST_SRC_SER0;
        3: rst_src = `ARX_RST_SRC_SER1;
        4: rst_src = `ARX_RST_SRC_REF0;
        default: rst_src = `ARX_RST_SRC_REF1;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // 16 kHz hold and 48 kHz phase

  // Fresh 16 kHz sample on its pulse, else the held one
  assign pipe0_h = pk_stb ? pipe_out_chan0 : pipe0_r;
  assign pipe1_h = pk_stb ? pipe_out_chan1 : pipe1_r;
  assign mic0_h = pk_stb ? mic_chan0 : mic0_r;
  assign mic1_h = pk_stb ? mic_chan1 : mic1_r;
  assign ref0_h = pk_stb ? ref16_chan0 : ref0_r;
  assign ref1_h = pk_stb ? ref16_chan1 : ref1_r;
  assign phase_cur = pk_stb ? 2'h0 :
                     (phase_r == `ARX_PACK_LAST_PHASE) ? phase_r : phase_r + 2'h1;

  // Latch 16 kHz samples so they repeat over three frames
  always @(posedge sys_clk) begin
    if (!rstn) begin
      phase_r <= 2'h0;
      pipe0_r <= {W{1'b0}};
      pipe1_r <= {W{1'b0}};
      mic0_r <= {W{1'b0}};
      mic1_r <= {W{1'b0}};
      ref0_r <= {W{1'b0}};
      ref1_r <= {W{1'b0}};
    end else if (in_stb) begin
      phase_r <= phase_cur;
      pipe0_r <= pipe0_h;
      pipe1_r <= pipe1_h;
      mic0_r <= mic0_h;
      mic1_r <= mic1_h;
      ref0_r <= ref0_h;
      ref1_r <= ref1_h;
    end
  end

  // Derived stereo sources
  assign host_mean = half2(host_in_chan0, host_in_chan1, 1'b0);
  assign host_hdiff = half2(host_in_chan0, host_in_chan1, 1'b1);
  assign ser_mean = half2(serial_in_chan0, serial_in_chan1, 1'b0);
  assign ser_hdiff = half2(serial_in_chan0, serial_in_chan1, 1'b1);

  ////////////////////////////////////////////////////////////////////////////
  // Per-destination source mux and gain

  genvar g;
  generate
    for (g = 0; g < `ARX_NUM_DST; g = g + 1) begin : g_dest
      localparam ODD = g % 2;
      reg [W-1:0] pick;
      // Source selection by code
      always @* begin
        pick = {W{1'b0}};
        case (src_act_r[g])
          `ARX_SRC_MUTE: pick = {W{1'b0}};
          `ARX_SRC_HOST_MEAN: pick = host_mean;
          `ARX_SRC_HOST_HDIFF: pick = host_hdiff;
          `ARX_SRC_SER_MEAN: pick = ser_mean;
          `ARX_SRC_SER_HDIFF: pick = ser_hdiff;
          `ARX_SRC_PIPE0: pick = pipe0_h;
          `ARX_SRC_PIPE1: pick = pipe1_h;
          `ARX_SRC_HOST0: pick = host_in_chan0;
          `ARX_SRC_HOST1: pick = host_in_chan1;
          `ARX_SRC_SER0: pick = serial_in_chan0;
          `ARX_SRC_SER1: pick = serial_in_chan1;
          `ARX_SRC_MIC0: pick = mic0_h;
          `ARX_SRC_MIC1: pick = mic1_h;
          `ARX_SRC_PACK_PIPE: pick = pack3(phase_cur, pipe0_h, pipe1_h, {W{1'b0}});
          `ARX_SRC_PACK_MIC: pick = pack3(phase_cur, mic0_h, mic1_h, {W{1'b0}});
          `ARX_SRC_PACK_REF: pick = pack3(phase_cur, ref0_h, ref1_h, {W{1'b0}});
          `ARX_SRC_PACK_ALL: pick = (ODD == 1) ? pack3(phase_cur, mic1_h, ref1_h, pipe1_h) :
                                    pack3(phase_cur, mic0_h, ref0_h, pipe0_h);
          default: pick = {W{1'b0}};
        endcase
      end
      arx_gain #(
        .W(W)
      ) u_gain (
        .din(pick),
        .shift(shift_act_r[g]),
        .dout(gained[g*W +: W])
      );
    end
  endgenerate

  // Register outputs once per frame, destination order fixed by index
  always @(posedge sys_clk) begin
    if (!rstn) begin
      host_out_chan0 <= {W{1'b0}};
      host_out_chan1 <= {W{1'b0}};
      serial_out_chan0 <= {W{1'b0}};
      serial_out_chan1 <= {W{1'b0}};
      echo_ref_chan0 <= {W{1'b0}};
      echo_ref_chan1 <= {W{1'b0}};
      out_stb <= 1'b0;
    end else begin
      out_stb <= in_stb;
      if (in_stb) begin
        host_out_chan0 <= gained[0*W +: W];
        host_out_chan1 <= gained[1*W +: W];
        serial_out_chan0 <= gained[2*W +: W];
        serial_out_chan1 <= gained[3*W +: W];
        echo_ref_chan0 <= gained[4*W +: W];
        echo_ref_chan1 <= gained[5*W +: W];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command handling

  assign cmd_take = cmd_valid & cmd_ready;
  assign dest_ok = (cmd_dest <= `ARX_DST_REF1);
  assign src_ok = (cmd_arg[7:5] == 3'h0) && (cmd_arg[4:0] <= `ARX_SRC_LAST);

  // Sequencer: idle accepts commands, dump streams readback words
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (cmd_take && cmd_op == `ARX_OP_READ) begin
          state_nxt = ST_DUMP;
        end
      end
      ST_DUMP: begin
        if (buf_in_ready && rb_idx_r == `ARX_DST_REF1) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Shadow settings are written by commands, active ones load per frame
  always @(posedge sys_clk) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
      cmd_ready <= 1'b0;
      cmd_err <= 1'b0;
      rb_idx_r <= 3'h0;
      for (i = 0; i < `ARX_NUM_DST; i = i + 1) begin
        src_sh_r[i] <= rst_src(i);
        src_act_r[i] <= rst_src(i);
        shift_sh_r[i] <= `ARX_RST_SHIFT;
        shift_act_r[i] <= `ARX_RST_SHIFT;
      end
    end else begin
      state_r <= state_nxt;
      cmd_ready <= (state_nxt == ST_IDLE);
      cmd_err <= 1'b0;
      if (state_r == ST_DUMP && buf_in_ready) begin
        rb_idx_r <= rb_idx_r + 3'h1;
      end else if (state_r == ST_IDLE) begin
        rb_idx_r <= 3'h0;
      end
      if (cmd_take) begin
        case (cmd_op)
          `ARX_OP_MAP: begin
            if (dest_ok && src_ok) begin
              src_sh_r[cmd_dest] <= cmd_arg[4:0];
              if (cmd_arg[4:0] == `ARX_SRC_PACK_ALL) begin
                src_sh_r[cmd_dest ^ 3'h1] <= `ARX_SRC_PACK_ALL;
              end
            end else begin
              cmd_err <= 1'b1;
            end
          end
          `ARX_OP_SHIFT: begin
            if (dest_ok) begin
              shift_sh_r[cmd_dest] <= cmd_arg;
            end else begin
              cmd_err <= 1'b1;
            end
          end
          `ARX_OP_READ: cmd_err <= 1'b0;
          default: cmd_err <= 1'b1;
        endcase
      end
      if (in_stb) begin
        for (i = 0; i < `ARX_NUM_DST; i = i + 1) begin
          src_act_r[i] <= src_sh_r[i];
          shift_act_r[i] <= shift_sh_r[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Readback path through the two-entry buffer

  assign buf_in_valid = (state_r == ST_DUMP);
  assign buf_in_data = {(rb_idx_r == `ARX_DST_REF1), rb_idx_r,
                        src_sh_r[rb_idx_r], shift_sh_r[rb_idx_r]};

  arx_skid2 #(
    .W(`ARX_RB_W)
  ) u_rb_buf (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(buf_in_data),
    .out_valid(rb_valid),
    .out_ready(rb_ready),
    .out_data(buf_out_data)
  );

  // Field split of the buffered word
  assign rb_last = buf_out_data[`ARX_RB_LAST_BIT];
  assign rb_dest = buf_out_data[`ARX_RB_DST_LSB +: 3];
  assign rb_src = buf_out_data[`ARX_RB_SRC_LSB +: 5];
  assign rb_shift = buf_out_data[`ARX_RB_SHIFT_LSB +: 8];

endmodule // arx_crossbar

// ==== dv/arx_chk_props.sv ====
// Checker on the crossbar ports: frame timing, commands and readback
`timescale 1ns/1ps
module arx_chk #(
  parameter W = 24
) (
  // Clock and reset
  input wire sys_clk,
  input wire rstn,
  // Frame strobes and routed outputs
  input wire in_stb,
  input wire out_stb,
  input wire [W-1:0] host_out_chan0,
  input wire [W-1:0] host_out_chan1,
  input wire [W-1:0] serial_out_chan0,
  input wire [W-1:0] serial_out_chan1,
  input wire [W-1:0] echo_ref_chan0,
  input wire [W-1:0] echo_ref_chan1,
  // Command port
  input wire cmd_valid,
  input wire cmd_ready,
  input wire [1:0] cmd_op,
  input wire [2:0] cmd_dest,
  input wire [7:0] cmd_arg,
  input wire cmd_err,
  // Readback stream
  input wire rb_valid,
  input wire rb_ready,
  input wire [2:0] rb_dest,
  input wire [4:0] rb_src,
  input wire [7:0] rb_shift,
  input wire rb_last
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  // Taken command, refused command and all routed outputs
  wire take = cmd_valid && cmd_ready;
  wire bad = cmd_op == 2'h3 || (cmd_op != 2'h2 && cmd_dest > 3'h5)
    || (cmd_op == 2'h0 && cmd_arg > 8'h10);
  wire [6*W-1:0] outs = {host_out_chan0, host_out_chan1, serial_out_chan0,
    serial_out_chan1, echo_ref_chan0, echo_ref_chan1};

  // Outputs move only with the output strobe, one cycle after a frame
  stb_follow_a: assert property (in_stb |=> out_stb)
    else $error("out_stb missing after in_stb");
  stb_quiet_a: assert property (!in_stb |=> !out_stb)
    else $error("out_stb without in_stb");
  out_hold_a: assert property (!out_stb |-> $stable(outs))
    else $error("output changed between frames");
  // Refused commands pulse the error flag, legal maps do not
  bad_cmd_a: assert property (take && bad |=> cmd_err)
    else $error("refused command without cmd_err");
  good_map_a: assert property (take && cmd_op == 2'h0 && !bad |=> !cmd_err)
    else $error("legal map flagged");
  // Readback dump: busy window, last word, stall hold, legal codes
  read_busy_a: assert property (take && cmd_op == 2'h2 |=> !cmd_ready [*5])
    else $error("cmd_ready high during dump");
  rb_last_a: assert property (rb_valid |-> rb_last == (rb_dest == 3'h5))
    else $error("rb_last not on destination 5");
  rb_hold_a: assert property (rb_valid && !rb_ready |=>
    rb_valid && $stable({rb_dest, rb_src, rb_shift, rb_last}))
    else $error("readback word lost in stall");
  rb_src_a: assert property (rb_valid |-> rb_src <= 5'h10)
    else $error("readback source out of range");

  // Main scenarios
  read_c: cover property (take && cmd_op == 2'h2);
  stall_c: cover property (rb_valid && !rb_ready);
  last_c: cover property (rb_valid && rb_ready && rb_last);
  err_c: cover property (cmd_err);
endmodule // arx_chk

bind arx_crossbar arx_chk #(.W(W)) chk_u (.*);

// ==== dv/arx_far.sv ====
// Far side model: frame timing source and readback sink
`timescale 1ns/1ps
module arx_far (
  // Clock, reset and stall request
  input wire sys_clk,
  input wire rstn,
  input wire stall,
  // Frame strobes and phase of the frame just sent
  output logic in_stb,
  output logic pk_stb,
  output logic [1:0] ph,
  // Readback sink handshake
  output logic rb_ready
);
  logic [2:0] cyc_r;
  logic [1:0] fr_r;

  // Quiet at time zero
  initial {in_stb, pk_stb, rb_ready} = 3'b0;

  // One frame in eight cycles, a 16 kHz sample every third frame
  always @(posedge sys_clk) begin
    if (!rstn) begin
      cyc_r <= 3'h0;
      fr_r <= 2'h0;
      in_stb <= 1'b0;
      pk_stb <= 1'b0;
      ph <= 2'h0;
      rb_ready <= 1'b0;
    end else begin
      cyc_r <= cyc_r + 3'h1;
      in_stb <= cyc_r == 3'h7;
      pk_stb <= cyc_r == 3'h7 && fr_r == 2'h0;
      rb_ready <= !stall || cyc_r[2]; // Slow sink stalls half the time
      if (cyc_r == 3'h7) begin
        ph <= fr_r;
        fr_r <= fr_r == 2'h2 ? 2'h0 : fr_r + 2'h1;
      end
    end
  end
endmodule // arx_far

// ==== dv/tb_top.sv ====
// Self-checking bench for the audio route crossbar
`timescale 1ns/1ps
module tb_top;
  logic sys_clk = 0, rstn = 0, stall = 0, cmd_valid = 0;
  logic in_stb, pk_stb, rb_ready, out_stb, cmd_ready, cmd_err, rb_valid, rb_last;
  logic [1:0] ph, cmd_op = 0;
  logic [2:0] cmd_dest = 0, rb_dest;
  logic [4:0] rb_src;
  logic [7:0] cmd_arg = 0, rb_shift;
  logic [23:0] host_in_chan0 = 24'h123456, host_in_chan1 = 24'hf00001;
  logic [23:0] serial_in_chan0 = 24'h7fffff, serial_in_chan1 = 24'h7ffffe;
  logic [23:0] pipe_out_chan0 = 24'h000321, pipe_out_chan1 = 24'h800000;
  logic [23:0] mic_chan0 = 24'h00abcd, mic_chan1 = 24'hfedcba;
  logic [23:0] ref16_chan0 = 24'h013579, ref16_chan1 = 24'h7a0000;
  logic [23:0] host_out_chan0, host_out_chan1, serial_out_chan0, serial_out_chan1;
  logic [23:0] echo_ref_chan0, echo_ref_chan1;
  logic [4:0] es [6] = '{5'h05, 5'h06, 5'h05, 5'h09, 5'h07, 5'h08};
  logic [7:0] eh [6] = '{default: 8'h00};
  int n_fail = 0, num_checks = 0;

  // Clock, design and far side
  always #4 sys_clk = ~sys_clk;
  arx_crossbar dut_u (.*);
  arx_far far_u (.*);

  ////////////////////////////////////////////////////////////////////////////
  // Expected sample of a source code in a given packing phase
  function automatic logic [23:0] srcv(logic [4:0] c, int d, logic [1:0] p);
    logic signed [24:0] hm, hd, sm, sd;
    hm = ($signed(host_in_chan0) + $signed(host_in_chan1)) >>> 1;
    hd = ($signed(host_in_chan0) - $signed(host_in_chan1)) >>> 1;
    sm = ($signed(serial_in_chan0) + $signed(serial_in_chan1)) >>> 1;
    sd = ($signed(serial_in_chan0) - $signed(serial_in_chan1)) >>> 1;
    case (c)
      5'd1: return hm[23:0];
      5'd2: return hd[23:0];
      5'd3: return sm[23:0];
      5'd4: return sd[23:0];
      5'd5: return pipe_out_chan0;
      5'd6: return pipe_out_chan1;
      5'd7: return host_in_chan0;
      5'd8: return host_in_chan1;
      5'd9: return serial_in_chan0;
      5'd10: return serial_in_chan1;
      5'd11: return mic_chan0;
      5'd12: return mic_chan1;
      5'd13: return p == 0 ? pipe_out_chan0 : p == 1 ? pipe_out_chan1 : 24'h0;
      5'd14: return p == 0 ? mic_chan0 : p == 1 ? mic_chan1 : 24'h0;
      5'd15: return p == 0 ? ref16_chan0 : p == 1 ? ref16_chan1 : 24'h0;
      5'd16: return d % 2 ? (p == 0 ? mic_chan1 : p == 1 ? ref16_chan1 : pipe_out_chan1)
        : (p == 0 ? mic_chan0 : p == 1 ? ref16_chan0 : pipe_out_chan0);
      default: return 24'h0;
    endcase
  endfunction

  // Expected power-of-two gain with saturation
  function automatic logic [23:0] gain(logic [23:0] x, logic signed [7:0] sh);
    logic signed [63:0] v;
    v = $signed(x);
    if (sh < 0) v = v >>> -sh;
    else v = v <<< sh;
    if (v > 64'sh7fffff) v = 64'sh7fffff;
    if (v < -64'sh800000) v = -64'sh800000;
    return v[23:0];
  endfunction

  // Routed output of one destination
  function automatic logic [23:0] outv(int d);
    case (d)
      0: return host_out_chan0;
      1: return host_out_chan1;
      2: return serial_out_chan0;
      3: return serial_out_chan1;
      4: return echo_ref_chan0;
      default: return echo_ref_chan1;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(string nm, logic [23:0] exp, logic [23:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s exp %h got %h", nm, exp, got);
    end
  endtask

  // Wait for the next output strobe
  task automatic wait_os;
    int n = 0;
    do @(posedge sys_clk); while (out_stb !== 1'b1 && ++n < 40);
    chk("out_stb", 1, out_stb);
  endtask

  // Hold one command until it is taken
  task automatic cmd(logic [1:0] op, logic [2:0] d, logic [7:0] a);
    int n = 0;
    @(posedge sys_clk);
    cmd_op <= op;
    cmd_dest <= d;
    cmd_arg <= a;
    cmd_valid <= 1'b1;
    do @(posedge sys_clk); while (cmd_ready !== 1'b1 && ++n < 40);
    chk("cmd_ready", 1, cmd_ready);
    cmd_valid <= 1'b0;
  endtask

  // Map or shift command, error flag check and model update
  task automatic req(logic [1:0] op, logic [2:0] d, logic [7:0] a);
    logic e;
    e = op == 2'h3 || d > 3'h5 || (op == 2'h0 && a > 8'h10);
    cmd(op, d, a);
    @(posedge sys_clk);
    chk("cmd_err", e, cmd_err);
    if (!e && op == 2'h0) es[d] = a[4:0];
    if (!e && op == 2'h0 && a == 8'h10) es[d ^ 1] = 5'h10;
    if (!e && op == 2'h1) eh[d] = a;
  endtask

  // Readback dump of all six destinations
  task automatic rd;
    int i = 0;
    int n = 0;
    cmd(2'h2, 3'h0, 8'h00);
    while (i < 6 && n++ < 200) begin
      @(posedge sys_clk);
      if (rb_valid === 1'b1 && rb_ready === 1'b1) begin
        chk("rb_dest", i, rb_dest);
        chk("rb_src", es[i], rb_src);
        chk("rb_shift", eh[i], rb_shift);
        chk("rb_last", i == 5, rb_last);
        i++;
      end
    end
    chk("rb_words", 6, i);
  endtask

  // Let settings land, then check every output over all three phases
  task automatic settle;
    wait_os();
    wait_os();
    for (int k = 0; k < 3; k++) begin
      wait_os();
      for (int d = 0; d < 6; d++)
        chk($sformatf("dest%0d", d), gain(srcv(es[d], d, ph), eh[d]), outv(d));
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Defaults after reset, read back through a stalling sink
  task automatic t_reset_state;
    stall <= 1'b1;
    settle();
    rd();
    stall <= 1'b0;
  endtask

  // Every source code, spread over all destinations
  task automatic t_all_codes;
    for (int c = 0; c <= 16; c++) begin
      req(2'h0, 3'(c % 6), 8'(c));
      settle();
    end
    stall <= 1'b1;
    rd();
    stall <= 1'b0;
  endtask

  // Mic sample held for three frames
  task automatic t_repeat;
    logic [23:0] old;
    int n = 0;
    req(2'h0, 3'h0, 8'h0b);
    settle();
    old = mic_chan0;
    do wait_os(); while (ph != 2'h0 && ++n < 4);
    mic_chan0 <= ~old;
    for (int k = 1; k <= 3; k++) begin
      wait_os();
      chk("mic_hold", k < 3 ? old : ~old, host_out_chan0);
    end
  endtask

  // Refused commands leave settings alone; a legal one follows at once
  task automatic t_refuse;
    req(2'h3, 3'h0, 8'h00);
    req(2'h0, 3'h6, 8'h05);
    req(2'h0, 3'h0, 8'h11);
    req(2'h1, 3'h7, 8'h01);
    req(2'h0, 3'h1, 8'h07);
    settle();
    rd();
  endtask

  // Left, right, saturating and sign-filling shifts
  task automatic t_shift;
    req(2'h1, 3'h0, 8'h04);
    req(2'h1, 3'h1, 8'hfe);
    req(2'h1, 3'h2, 8'h14);
    req(2'h1, 3'h5, 8'he2);
    settle();
    rd();
  endtask

  // Verdict and end of run
  task automatic summarize;
    $display("Checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    t_reset_state();
    t_all_codes();
    t_repeat();
    t_refuse();
    t_shift();
    summarize();
  end

  // Watchdog: the run needs about 1000 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    $display("Error watchdog exp done got timeout");
    summarize();
  end
endmodule // tb_top
